// [det_remote_dac.sv]
// Remote command interpreter, correction store and DAC update scheduler
//
// Behaviour
// - Readback selector 14 sends four 21-bit offset values of frequency 3.
// - Readback selector 16 sends the three 14-bit field voltage values.
// - Field voltages are fixed at build time; no command writes them.
// - Functions 16..27 write one gain value from four bytes, MSB first.
// - Gain values range 0..5.0, carried as value times 200000.
// - Functions 28..31 write one fixed gain from two bytes, upper first.
// - Functions 32..43 write one offset value from four bytes, MSB first.
// - Offsets span -100000..100000 in sign-magnitude, sign in top bit.
// - Twelve 12-bit DAC codes update from mode-selected results.
// - No DAC update while menu is active or a command executes.
// - Angle mode updates one, two or four channels at 4, 2, 1 kHz.
// - Vector length mode outputs three lengths per processed channel.
// - Vector angle mode outputs three angles per processed channel.
// - Vector lengths are scaled so the dominant vector fills the range.
// - Vector angles map minus pi to plus pi onto the full span.
// - DAC span select follows the output range setting.
`default_nettype none
module det_remote_dac #(
  parameter int          TICK_PERIOD = dac_cmd_pkg::TICK_CYCLES,
  parameter logic [13:0] FIELD_F1    = 14'h2000,
  parameter logic [13:0] FIELD_F2    = 14'h2000,
  parameter logic [13:0] FIELD_F3    = 14'h2000
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [95:0]   angle_in,
  input  wire logic [191:0]  vlen_in,
  input  wire logic [191:0]  vang_in,
  output logic [143:0]       dac_code,
  output logic               dac_update,
  output logic [1:0]         dac_range,
  output logic [251:0]       gain_corr,
  output logic [251:0]       offset_corr,
  output logic [31:0]        fixed_gain,
  output logic               resp_valid,
  output logic               resp_first,
  output logic [20:0]        resp_data,
  output logic               cmd_busy
);
  import dac_cmd_pkg::*;

  localparam int TW = $clog2(TICK_PERIOD);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_PERIOD - 1);

  logic [CTRL_W-1:0] ctrl;
  logic              reject;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [7:0]        fifo_data;
  logic [4:0]        fifo_level;
  cmd_state_t        state;
  logic [7:0]        func;
  logic [2:0]        need;
  logic [31:0]       asm_val;
  logic [1:0]        word;
  logic [2:0]        rb_len;
  logic [20:0]       rb_word;
  logic              bad_apply;
  logic              bad_func;

  wire omode_t om = omode_t'(ctrl[CTRL_OMODE_LSB +: 2]);
  wire pmode_t pm = pmode_t'(ctrl[CTRL_PMODE_LSB +: 2]);
  wire logic   menu = ctrl[CTRL_MENU_BIT];

  // APB slave; pready waits while a command write would overflow the FIFO
  wire logic is_cmd   = (paddr == ADDR_CMD);
  wire logic mapped   = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) |
                        is_cmd;
  wire logic finish   = psel & penable & pready;
  wire logic stall    = pwrite & is_cmd & ~fifo_in_ready;
  wire logic wr_ctrl  = finish & pwrite & (paddr == ADDR_CTRL);
  wire logic wr_stat  = finish & pwrite & (paddr == ADDR_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready & ~stall;
      if (psel & penable & ~pready & ~stall) begin
        pslverr <= ~mapped;
        prdata  <= 32'h00000000;
        if (!pwrite && paddr == ADDR_CTRL) begin
          prdata[CTRL_W-1:0] <= ctrl;
        end else if (!pwrite && paddr == ADDR_STATUS) begin
          prdata[STAT_BUSY_BIT] <= cmd_busy;
          prdata[STAT_REJ_BIT]  <= reject;
          prdata[STAT_LEVEL_LSB +: 5] <= fifo_level;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reject <= 1'b0;
    end else if (bad_apply | bad_func) begin
      reject <= 1'b1;
    end else if (wr_stat & pwdata[STAT_REJ_BIT]) begin
      reject <= 1'b0;
    end
  end

  cmd_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (finish & pwrite & is_cmd),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  function automatic logic [2:0] data_bytes(input logic [7:0] fn);
    if (fn == FN_READBACK) begin
      return 3'd1;
    end else if (fn >= FN_GAIN_FIRST && fn <= FN_GAIN_LAST) begin
      return 3'd4;
    end else if (fn >= FN_FIX_FIRST && fn <= FN_FIX_LAST) begin
      return 3'd2;
    end else if (fn >= FN_OFFS_FIRST && fn <= FN_OFFS_LAST) begin
      return 3'd4;
    end
    return 3'd0;
  endfunction : data_bytes

  assign fifo_out_ready = fifo_out_valid &
                          (state == ST_FUNC || state == ST_DATA);
  assign bad_func = (state == ST_FUNC) & fifo_out_ready &
                    (data_bytes(fifo_data) == 3'd0);

  // Command sequencer: function byte, data bytes, apply, optional packet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= ST_FUNC;
      func    <= 8'h00;
      need    <= 3'd0;
      asm_val <= 32'h00000000;
      word    <= 2'd0;
    end else begin
      case (state)
        ST_FUNC: begin
          if (fifo_out_ready && data_bytes(fifo_data) != 3'd0) begin
            func    <= fifo_data;
            need    <= data_bytes(fifo_data);
            asm_val <= 32'h00000000;
            state   <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (fifo_out_ready) begin
            asm_val <= {asm_val[23:0], fifo_data};
            need    <= need - 3'd1;
            if (need == 3'd1) begin
              state <= ST_APPLY;
            end
          end
        end
        ST_APPLY: begin
          word  <= 2'd0;
          state <= (func == FN_READBACK && rb_len != 3'd0) ? ST_SEND
                                                          : ST_FUNC;
        end
        ST_SEND: begin
          word <= word + 2'd1;
          if ({1'b0, word} == rb_len - 3'd1) begin
            state <= ST_FUNC;
          end
        end
        default: state <= ST_FUNC;
      endcase
    end
  end

  // Limit checks on the fully assembled value
  wire logic is_gain = func >= FN_GAIN_FIRST && func <= FN_GAIN_LAST;
  wire logic is_fix  = func >= FN_FIX_FIRST && func <= FN_FIX_LAST;
  wire logic is_offs = func >= FN_OFFS_FIRST && func <= FN_OFFS_LAST;
  wire logic gain_ok = asm_val[31:21] == 11'h000 &&
                       asm_val[20:0] <= GAIN_MAX;
  wire logic fix_ok  = asm_val[15:8] == 8'h00;
  wire logic offs_ok = asm_val[30:20] == 11'h000 &&
                       asm_val[19:0] <= OFFS_MAX;
  wire logic [3:0] gidx = 4'(func - FN_GAIN_FIRST);
  wire logic [3:0] oidx = 4'(func - FN_OFFS_FIRST);
  wire logic [1:0] fidx = 2'(func - FN_FIX_FIRST);
  wire logic applying = (state == ST_APPLY);

  assign bad_apply = applying &
                     ((is_gain & ~gain_ok) | (is_fix & ~fix_ok) |
                      (is_offs & ~offs_ok) |
                      (func == FN_READBACK & rb_len == 3'd0));

  // Stores change only in the apply state, never mid-assembly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_corr   <= {NCORR{GAIN_RESET}};
      offset_corr <= {NCORR{OFFS_RESET}};
      fixed_gain  <= {4{FIX_RESET}};
    end else if (applying) begin
      if (is_gain && gain_ok) begin
        gain_corr[gidx*PARAM_W +: PARAM_W] <= asm_val[20:0];
      end
      if (is_fix && fix_ok) begin
        fixed_gain[fidx*8 +: 8] <= asm_val[7:0];
      end
      if (is_offs && offs_ok) begin
        offset_corr[oidx*PARAM_W +: PARAM_W] <=
          {asm_val[31], asm_val[19:0]};
      end
    end
  end

  // Readback packet selection; index is channel*3 + frequency
  always_comb begin
    rb_len  = 3'd0;
    rb_word = 21'h000000;
    case (asm_val[7:0])
      RB_GAIN_F1, RB_GAIN_F2, RB_GAIN_F3: begin
        rb_len  = 3'd4;
        rb_word = gain_corr[(word*3 + asm_val[1:0])*PARAM_W +: PARAM_W];
      end
      RB_FIX: begin
        rb_len  = 3'd4;
        rb_word = {13'h0000, fixed_gain[word*8 +: 8]};
      end
      RB_OFFS_F1, RB_OFFS_F2, RB_OFFS_F3: begin
        rb_len  = 3'd4;
        rb_word = offset_corr[(word*3 + asm_val[1:0])*PARAM_W +: PARAM_W];
      end
      RB_FIELD: begin
        rb_len = 3'd3;
        case (word)
          2'd0:    rb_word = {7'h00, FIELD_F1};
          2'd1:    rb_word = {7'h00, FIELD_F2};
          default: rb_word = {7'h00, FIELD_F3};
        endcase
      end
      default: begin
        rb_len  = 3'd0;
        rb_word = 21'h000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
      resp_first <= 1'b0;
      resp_data  <= 21'h000000;
      cmd_busy   <= 1'b0;
    end else begin
      resp_valid <= (state == ST_SEND);
      resp_first <= (state == ST_SEND) && word == 2'd0;
      resp_data  <= (state == ST_SEND) ? rb_word : 21'h000000;
      cmd_busy   <= (state != ST_FUNC) | fifo_out_valid;
    end
  end

  // Base 4 kHz tick; slower rates come from the phase counter
  logic [TW-1:0] tick_cnt;
  logic [1:0]    phase;
  wire logic tick = (tick_cnt == TICK_LAST);
  wire logic executing = (state != ST_FUNC) | fifo_out_valid;
  wire logic rate_hit = (pm == two_channel_processing) ? ~phase[0] :
                        (pm == four_channel_processing) ?
                        (phase == 2'd0) : 1'b1;
  wire logic do_update = tick & rate_hit & ~menu & ~executing;
  wire logic [2:0] nch = (pm == two_channel_processing) ? 3'd2 :
                         (pm == four_channel_processing) ? 3'd4 : 3'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
      phase    <= 2'd0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick) begin
        phase <= phase + 2'd1;
      end
    end
  end

  // Magnitude saturates so that the most negative code cannot overflow
  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'h8000) ? 16'h8001 : v;
  endfunction : sat

  // Dominant magnitude over processed channels sets a common shift
  logic [14:0] vmax;
  logic [3:0]  vshift;
  always_comb begin
    logic [15:0] s;
    logic [14:0] m;
    s = 16'h0000;
    m = 15'h0000;
    vmax = 15'h0000;
    vshift = 4'd0;
    for (int i = 0; i < NDAC; i++) begin
      s = sat(vlen_in[i*SAMP_W +: SAMP_W]);
      m = s[15] ? 15'(-s) : s[14:0];
      if (i / 3 < int'(nch) && m > vmax) begin
        vmax = m;
      end
    end
    for (int b = 0; b < 15; b++) begin
      if (vmax[b]) begin
        vshift = 4'(14 - b);
      end
    end
  end

  for (genvar d = 0; d < NDAC; d++) begin : g_dac
    wire logic [15:0] lv = sat(vlen_in[d*SAMP_W +: SAMP_W]);
    wire logic [15:0] ls = 16'(lv <<< vshift);
    wire logic [11:0] va = vang_in[d*SAMP_W + 4 +: DAC_W];
    // Only eight angle lanes exist; upper DACs never select one
    wire logic [11:0] av = angle_in[(d % 8)*DAC_W +: DAC_W];
    wire logic ang_on = d < 8 && (d / 2) < int'(nch);
    wire logic vec_on = (d / 3) < int'(nch);
    logic [DAC_W-1:0] code;
    assign dac_code[d*DAC_W +: DAC_W] = code;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        code <= DAC_MID;
      end else if (do_update) begin
        if (om == OM_ANGLE && ang_on) begin
          code <= av ^ DAC_MID;
        end else if (om == OM_VLEN && vec_on) begin
          code <= ls[15:4] ^ DAC_MID;
        end else if (om == OM_VANG && vec_on) begin
          code <= va ^ DAC_MID;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_update <= 1'b0;
      dac_range  <= 2'd0;
    end else begin
      dac_update <= do_update;
      dac_range  <= ctrl[CTRL_RANGE_LSB +: 2];
    end
  end

  property p_freeze;
    @(posedge pclk) disable iff (!presetn)
    dac_update |-> !$past(menu) && !$past(executing);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("DAC updated while frozen");

  property p_offs_packet;
    @(posedge pclk) disable iff (!presetn)
    (applying && func == FN_READBACK && asm_val[7:0] == RB_OFFS_F3)
    |=> ##1 resp_valid [*4] ##1 !resp_valid;
  endproperty
  a_offs_packet: assert property (p_offs_packet)
    else $error("Offset readback packet not four words");

  property p_field_packet;
    @(posedge pclk) disable iff (!presetn)
    (applying && func == FN_READBACK && asm_val[7:0] == RB_FIELD)
    |=> ##1 (resp_valid && resp_data == {7'h00, FIELD_F1})
        ##2 (resp_valid && resp_data == {7'h00, FIELD_F3}) ##1 !resp_valid;
  endproperty
  a_field_packet: assert property (p_field_packet)
    else $error("Field voltage packet wrong");

  property p_gain_write;
    @(posedge pclk) disable iff (!presetn)
    (applying && is_gain && gain_ok) |=>
      gain_corr[$past(gidx)*PARAM_W +: PARAM_W] == $past(asm_val[20:0]);
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("Gain value not stored");

  property p_gain_stable;
    @(posedge pclk) disable iff (!presetn)
    !$past(applying) |-> $stable(gain_corr) && $stable(offset_corr) &&
                         $stable(fixed_gain);
  endproperty
  a_gain_stable: assert property (p_gain_stable)
    else $error("Store changed outside apply");

  property p_offs_write;
    @(posedge pclk) disable iff (!presetn)
    (applying && is_offs && offs_ok) |=>
      offset_corr[$past(oidx)*PARAM_W +: PARAM_W] ==
      {$past(asm_val[31]), $past(asm_val[19:0])};
  endproperty
  a_offs_write: assert property (p_offs_write)
    else $error("Offset value not stored as sign-magnitude");

  property p_range;
    @(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> ##1 dac_range == $past(pwdata[CTRL_RANGE_LSB +: 2], 2);
  endproperty
  a_range: assert property (p_range)
    else $error("DAC range not following setting");

  property p_vang;
    @(posedge pclk) disable iff (!presetn)
    (do_update && om == OM_VANG) |=>
      dac_code[DAC_W-1:0] == ($past(vang_in[15:4]) ^ DAC_MID);
  endproperty
  a_vang: assert property (p_vang)
    else $error("Vector angle code wrong");

  property p_rate;
    @(posedge pclk) disable iff (!presetn)
    (do_update && pm == four_channel_processing) |-> phase == 2'd0;
  endproperty
  a_rate: assert property (p_rate)
    else $error("Four channel update off its phase");

  c_update: cover property (@(posedge pclk) disable iff (!presetn)
    dac_update && om == OM_VLEN);
  c_field: cover property (@(posedge pclk) disable iff (!presetn)
    resp_first && func == FN_READBACK && asm_val[7:0] == RB_FIELD);
  c_stall: cover property (@(posedge pclk) disable iff (!presetn)
    psel && penable && stall);
  c_reject: cover property (@(posedge pclk) disable iff (!presetn)
    bad_apply);
endmodule : det_remote_dac
`default_nettype wire

// [dac_cmd_pkg.sv]
// Shared constants and types for the remote command and DAC update block
`default_nettype none
package dac_cmd_pkg;
  // Timing
  localparam int CLK_HZ       = 250_000_000;
  localparam int BASE_RATE_HZ = 4000;
  localparam int TICK_CYCLES  = CLK_HZ / BASE_RATE_HZ;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CMD    = 8'h08;

  // Control fields
  localparam int CTRL_W         = 7;
  localparam int CTRL_OMODE_LSB = 0;
  localparam int CTRL_PMODE_LSB = 2;
  localparam int CTRL_RANGE_LSB = 4;
  localparam int CTRL_MENU_BIT  = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Status fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_REJ_BIT   = 1;
  localparam int STAT_LEVEL_LSB = 8;

  // Function numbers
  localparam logic [7:0] FN_READBACK   = 8'h0F;
  localparam logic [7:0] FN_GAIN_FIRST = 8'h10;
  localparam logic [7:0] FN_GAIN_LAST  = 8'h1B;
  localparam logic [7:0] FN_FIX_FIRST  = 8'h1C;
  localparam logic [7:0] FN_FIX_LAST   = 8'h1F;
  localparam logic [7:0] FN_OFFS_FIRST = 8'h20;
  localparam logic [7:0] FN_OFFS_LAST  = 8'h2B;

  // Readback selectors carried in the first data byte
  localparam logic [7:0] RB_GAIN_F1 = 8'h04;
  localparam logic [7:0] RB_GAIN_F2 = 8'h05;
  localparam logic [7:0] RB_GAIN_F3 = 8'h06;
  localparam logic [7:0] RB_FIX     = 8'h08;
  localparam logic [7:0] RB_OFFS_F1 = 8'h0C;
  localparam logic [7:0] RB_OFFS_F2 = 8'h0D;
  localparam logic [7:0] RB_OFFS_F3 = 8'h0E;
  localparam logic [7:0] RB_FIELD   = 8'h10;

  // Value widths, limits and reset values
  localparam int PARAM_W = 21;
  localparam int FIELD_W = 14;
  localparam int NCORR   = 12;
  localparam int NDAC    = 12;
  localparam int DAC_W   = 12;
  localparam int SAMP_W  = 16;
  localparam logic [20:0] GAIN_MAX   = 21'h0F4240;
  localparam logic [19:0] OFFS_MAX   = 20'h186A0;
  localparam logic [20:0] GAIN_RESET = 21'h030D40;
  localparam logic [20:0] OFFS_RESET = 21'h000000;
  localparam logic [7:0]  FIX_RESET  = 8'h00;
  localparam logic [11:0] DAC_MID    = 12'h800;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [1:0] {OM_ANGLE, OM_VLEN, OM_VANG, OM_RSVD} omode_t;
  typedef enum logic [1:0] {
    single_channel_processing,
    two_channel_processing,
    four_channel_processing,
    PM_RSVD
  } pmode_t;
  typedef enum {ST_FUNC, ST_DATA, ST_APPLY, ST_SEND} cmd_state_t;
endpackage : dac_cmd_pkg
`default_nettype wire

// [cmd_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH+1)-1:0]    level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [$clog2(DEPTH+1)-1:0] FULL = DEPTH[$clog2(DEPTH+1)-1:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = (level != FULL);
  assign out_valid = (level != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        level <= level + 1'b1;
      end else if (pop & ~push) begin
        level <= level - 1'b1;
      end
    end
  end
endmodule : cmd_fifo
`default_nettype wire

// [dummy_end.sv]
// Intentionally empty compilation unit
`default_nettype none
`default_nettype wire

// [host_model.sv]
// Remote host model: collects readback packet words
`default_nettype none
module host_model (
  input wire logic        pclk,
  input wire logic        resp_valid,
  input wire logic        resp_first,
  input wire logic [20:0] resp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] words[$];
  int          firsts = 0;
  // Records every word seen with resp_valid high and counts first words
  always @(posedge pclk) begin
    if (resp_valid === 1'b1) begin
      words.push_back(resp_data);
      if (resp_first === 1'b1) firsts++;
    end
  end
endmodule : host_model
`default_nettype wire

// [tb_top.sv]
// Testbench for the remote command and DAC update block
`default_nettype none
module tb_top;
  import dac_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TP = 20;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]   paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rd, fixed_gain;
  logic         pready, pslverr, er, dac_update, resp_valid, resp_first;
  logic         cmd_busy;
  logic [95:0]  angle_in = 96'h123;
  logic [191:0] vlen_in = 192'h0100_0400, vang_in = 192'h8000;
  logic [143:0] dac_code;
  logic [1:0]   dac_range;
  logic [251:0] gain_corr, offset_corr;
  logic [20:0]  resp_data;
  logic [11:0]  ecode[3] = '{12'h923, 12'hC00, 12'h000};
  int           miscompares = 0, samples_checked = 0, cyc = 0, n;

  det_remote_dac #(.TICK_PERIOD(TP)) i_det_remote_dac (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .angle_in, .vlen_in, .vang_in, .dac_code,
    .dac_update, .dac_range, .gain_corr, .offset_corr, .fixed_gain,
    .resp_valid, .resp_first, .resp_data, .cmd_busy);
  host_model i_host_model (.pclk, .resp_valid, .resp_first, .resp_data);

  initial begin
    forever #2 pclk = ~pclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Request held until the edge that samples pready high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic cmd(logic [7:0] b[$]);
    foreach (b[i]) apb(1, ADDR_CMD, {24'h0, b[i]});
    do begin
      @(posedge pclk);
    end while (cmd_busy !== 1'b0);
  endtask : cmd

  task automatic rb(logic [7:0] sel, logic [20:0] e[$]);
    i_host_model.words.delete();
    i_host_model.firsts = 0;
    cmd('{FN_READBACK, sel});
    n = 0;
    while (i_host_model.words.size() < e.size() && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk("rb_count", i_host_model.words.size(), e.size());
    chk("rb_first", i_host_model.firsts, 1);
    foreach (e[i]) chk("rb_word", i_host_model.words[i], e[i]);
  endtask : rb

  // Counts cycles up to the next update pulse; 400 means none came
  task automatic waitupd();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (dac_update !== 1'b1 && n < 400);
  endtask : waitupd

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    chk("gain_rst", gain_corr[20:0], GAIN_RESET);
    chk("dac_rst", dac_code[11:0], DAC_MID);
    cmd('{8'h1B, 8'h00, 8'h0F, 8'h42, 8'h40});
    chk("gain11", gain_corr[231+:21], 21'h0F4240);
    cmd('{8'h10, 8'h00, 8'h0F, 8'h42, 8'h41});
    chk("gain_bad", gain_corr[20:0], GAIN_RESET);
    apb(0, ADDR_STATUS, 0);
    chk("reject", rd[1], 1);
    apb(1, ADDR_STATUS, 2);
    apb(0, ADDR_STATUS, 0);
    chk("reject_clr", rd[1], 0);
    cmd('{8'h1F, 8'h00, 8'hFF});
    chk("fix3", fixed_gain[31:24], 8'hFF);
    cmd('{8'h2B, 8'h80, 8'h01, 8'h86, 8'hA0});
    chk("offs11", offset_corr[231+:21], 21'h1186A0);
    cmd('{8'h22, 8'h00, 8'h00, 8'h00, 8'h05});
    rb(8'h0E, '{21'h5, 21'h0, 21'h0, 21'h1186A0});
    rb(8'h10, '{21'h2000, 21'h2000, 21'h2000});
    rb(8'h06, '{GAIN_RESET, GAIN_RESET, GAIN_RESET, 21'h0F4240});
    rb(8'h08, '{21'h0, 21'h0, 21'h0, 21'hFF});
    apb(0, 8'h0C, 0);
    chk("unmapped", er, 1);
    // Two updates so the first one under the old mode is skipped
    foreach (ecode[m]) begin
      apb(1, ADDR_CTRL, 32'h20 | m);
      waitupd();
      waitupd();
      chk("dac0", dac_code[11:0], ecode[m]);
    end
    chk("range", dac_range, 2'h2);
    apb(1, ADDR_CTRL, 32'h1);
    waitupd();
    waitupd();
    chk("vlen1", dac_code[23:12], 12'h900);
    for (int p = 0; p < 3; p++) begin
      apb(1, ADDR_CTRL, p << 2);
      repeat (3) waitupd();
      chk("gap", n, TP << p);
    end
    apb(1, ADDR_CTRL, 32'h40);
    repeat (2) @(posedge pclk);
    waitupd();
    chk("menu", n, 400);
    results();
  end
endmodule : tb_top
`default_nettype wire
